// ==== tb_tsm_top.sv ====
// Self-checking bench for the sampler and mirror probe block
`timescale 1ns/1ps
`default_nettype none

bind tsm_top tsm_assertions tsm_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .frm_valid_i(frm_valid_i),
	.smp_valid_o(smp_valid_o), .smp_port_o(smp_port_o), .smp_tx_o(smp_tx_o),
	.smp_queue_o(smp_queue_o), .smp_marker_o(smp_marker_o),
	.smp_stamp_o(smp_stamp_o), .mir_valid_o(mir_valid_o),
	.mir_probe_o(mir_probe_o), .stat_evt_o(stat_evt_o));

module tb_tsm_top;
	logic	clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic	send = 1'b0, ack_o, smp_valid_o, smp_tx_o, smp_marker_o, mir_valid_o;
	logic	[11:0] adr_i = 12'h000;
	logic	[3:0] sel_i = 4'h0, smp_port_o, mir_dst_port_o, stat_port_o;
	logic	[31:0] dat_i = 32'h0, dat_o, smp_stamp_o;
	logic	[37:0] desc = 38'h0, frm_o;
	logic	[2:0] smp_queue_o, stat_evt_o;
	logic	[1:0] mir_probe_o;
	wire logic	frm_valid_i, vf, sm, dm, fl, cv;
	wire logic	[3:0] frm_src_port_i;
	wire logic	[14:0] frm_dst_mask_i;
	wire logic	[11:0] frm_vid_i;
	wire logic	[1:0] frm_cls_probe_i;
	int	failures = 0;
	int	n_tests = 0;
	int	cycles = 0;

	assign {frm_src_port_i, frm_dst_mask_i, frm_vid_i, vf, sm, dm, fl, cv, frm_cls_probe_i} = frm_o;

	tsm_fwd_model tsm_fwd_model_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
		.desc_i(desc), .frm_valid_o(frm_valid_i), .frm_o(frm_o));

	tsm_top tsm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .frm_valid_i(frm_valid_i), .frm_src_port_i(frm_src_port_i),
		.frm_dst_mask_i(frm_dst_mask_i), .frm_vid_i(frm_vid_i), .frm_vlan_mirror_i(vf),
		.frm_smac_mirror_i(sm), .frm_dmac_mirror_i(dm), .frm_flooded_i(fl),
		.frm_cls_probe_valid_i(cv), .frm_cls_probe_i(frm_cls_probe_i),
		.smp_valid_o(smp_valid_o), .smp_port_o(smp_port_o), .smp_tx_o(smp_tx_o),
		.smp_queue_o(smp_queue_o), .smp_marker_o(smp_marker_o),
		.smp_stamp_o(smp_stamp_o), .mir_valid_o(mir_valid_o), .mir_probe_o(mir_probe_o),
		.mir_dst_port_o(mir_dst_port_o), .stat_evt_o(stat_evt_o), .stat_port_o(stat_port_o));

	always #5 clk_i = ~clk_i;

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// Classic single cycle; waits for ack with a bound
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int t;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 50);
		if (t == 50) failures++;
		r = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask

	// Frame reaches the block one edge after send; results one edge later
	task automatic frm(input logic [3:0] s, input logic [14:0] m, input logic [11:0] v,
			input logic [3:0] f, input logic [2:0] c);
		@(posedge clk_i);
		desc <= {s, m, v, f, c};
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	task automatic exs(input logic v, input logic [3:0] p, input logic t, input logic [31:0] s);
		chk("smp_valid", smp_valid_o, v);
		if (v) begin
			chk("smp_port", smp_port_o, p);
			chk("smp_tx", smp_tx_o, t);
			chk("smp_queue", smp_queue_o, 3'h5);
			chk("smp_marker", smp_marker_o, 1'b1);
			chk("smp_stamp", smp_stamp_o, s);
		end
	endtask

	task automatic exm(input logic v, input logic [1:0] p, input logic [3:0] d);
		chk("mir_valid", mir_valid_o, v);
		if (v) begin
			chk("mir_probe", mir_probe_o, p);
			chk("mir_dst", mir_dst_port_o, d);
		end
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("common", 12'h000, 32'h0);
		wr(12'hFFC, 32'hFFFF_FFFF);
		rd("unmapped", 12'hFFC, 32'h0);
		rd("copies", 12'h080, 32'h0);
		$display("end reset_and_map");
		wr(12'h000, 32'h0000_0053);
		wr(12'h048, 32'h0001_8000);
		frm(4'h2, 15'h0, 12'h0, 4'h0, 3'h0);
		exs(1'b1, 4'h2, 1'b0, 32'h0800_0101);
		chk("evt_masked", stat_evt_o, 3'h0);
		wr(12'h008, 32'h0000_0007);
		frm(4'h2, 15'h0, 12'h0, 4'h0, 3'h0);
		exs(1'b1, 4'h2, 1'b0, 32'h0800_0202);
		chk("evt_rx", stat_evt_o, 3'h3);
		rd("copies2", 12'h088, 32'h2);
		rd("cand2", 12'h0C8, 32'h2);
		rd("sticky", 12'h004, 32'h3);
		wr(12'h004, 32'h0000_0003);
		rd("sticky_clr", 12'h004, 32'h0);
		$display("end rx_sampling");
		wr(12'h050, 32'h0002_8000);
		frm(4'h0, 15'h0010, 12'h0, 4'h0, 3'h0);
		exs(1'b1, 4'h4, 1'b1, 32'h1000_0101);
		chk("evt_tx", stat_evt_o, 3'h5);
		chk("stat_port_tx", stat_port_o, 4'h4);
		frm(4'h2, 15'h0010, 12'h0, 4'h0, 3'h0);
		exs(1'b1, 4'h2, 1'b0, 32'h0800_0303);
		rd("cand4", 12'h0D0, 32'h2);
		rd("copies4", 12'h090, 32'h1);
		$display("end tx_sampling");
		wr(12'h054, 32'h0001_0000);
		frm(4'h5, 15'h0, 12'h0, 4'h0, 3'h0);
		exs(1'b0, 4'h0, 1'b0, 32'h0);
		chk("evt_cand", stat_evt_o, 3'h1);
		chk("stat_port_rx", stat_port_o, 4'h5);
		rd("cand5", 12'h0D4, 32'h1);
		wr(12'h000, 32'h0);
		frm(4'h2, 15'h0, 12'h0, 4'h0, 3'h0);
		exs(1'b0, 4'h0, 1'b0, 32'h0);
		rd("cand_off", 12'h0C8, 32'h3);
		wr(12'h000, 32'h0000_0051);
		frm(4'h2, 15'h0, 12'h0, 4'h0, 3'h0);
		exs(1'b1, 4'h2, 1'b0, 32'h0000_0404);
		$display("end rate_and_enable");
		wr(12'h110, 32'h0B00_00E2);
		wr(12'h114, 32'h0000_0008);
		rd("probe1", 12'h110, 32'h0B00_00E2);
		frm(4'h3, 15'h0, 12'h003, 4'h0, 3'h0);
		exm(1'b1, 2'h1, 4'hB);
		frm(4'h3, 15'h0, 12'h004, 4'h0, 3'h0);
		exm(1'b0, 2'h0, 4'h0);
		wr(12'h120, 32'h0900_0001);
		wr(12'h124, 32'h0000_0010);
		frm(4'h3, 15'h0010, 12'h003, 4'h0, 3'h0);
		exm(1'b1, 2'h2, 4'h9);
		$display("end probe_priority");
		wr(12'h100, 32'h0700_0012);
		frm(4'h0, 15'h0, 12'h0, 4'h0, 3'h4);
		exm(1'b1, 2'h0, 4'h7);
		wr(12'h104, 32'h0000_0001);
		frm(4'h0, 15'h0, 12'h0, 4'h8, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		frm(4'h0, 15'h0, 12'h0, 4'h0, 3'h0);
		exm(1'b0, 2'h0, 4'h0);
		wr(12'h100, 32'h0710_0002);
		frm(4'hB, 15'h0, 12'h0, 4'h0, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		frm(4'hC, 15'h0, 12'h0, 4'h0, 3'h0);
		exm(1'b0, 2'h0, 4'h0);
		wr(12'h100, 32'h0708_0001);
		frm(4'h0, 15'h1000, 12'h0, 4'h0, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		$display("end probe_filters");
		wr(12'h100, 32'h0700_000A);
		frm(4'h0, 15'h0, 12'h0, 4'h0, 3'h0);
		exm(1'b0, 2'h0, 4'h0);
		frm(4'h0, 15'h0, 12'h0, 4'h4, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		wr(12'h100, 32'h0700_0006);
		frm(4'h0, 15'h0, 12'h0, 4'h1, 3'h0);
		exm(1'b0, 2'h0, 4'h0);
		wr(12'h000, 32'h0000_0100);
		frm(4'h0, 15'h0, 12'h0, 4'h1, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		frm(4'h0, 15'h0, 12'h0, 4'h2, 3'h0);
		exm(1'b1, 2'h0, 4'h7);
		$display("end station_filter");
		final_report();
	end
endmodule

`default_nettype wire

// ==== tsm_assertions.sv ====
// Concurrent checks on the sampler, mirror and bus ports
`timescale 1ns/1ps
`default_nettype none

module tsm_assertions (
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// Bus
	input wire logic	cyc_i,
	input wire logic	stb_i,
	input wire logic	we_i,
	input wire logic [11:0]	adr_i,
	input wire logic [3:0]	sel_i,
	input wire logic [31:0]	dat_i,
	input wire logic [31:0]	dat_o,
	input wire logic	ack_o,
	// Frame and copies
	input wire logic	frm_valid_i,
	input wire logic	smp_valid_o,
	input wire logic [3:0]	smp_port_o,
	input wire logic	smp_tx_o,
	input wire logic [2:0]	smp_queue_o,
	input wire logic	smp_marker_o,
	input wire logic [31:0]	smp_stamp_o,
	input wire logic	mir_valid_o,
	input wire logic [1:0]	mir_probe_o,
	input wire logic [2:0]	stat_evt_o
);
	logic	[2:0] qsel_q;
	logic	idena_q;
	logic	gena_q;
	wire logic	com_wr = cyc_i && stb_i && we_i && ack_o && adr_i[11:2] == 10'h000 && sel_i[0];

	// Shadow of the common register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{qsel_q, idena_q, gena_q} <= 5'h00;
		end else if (com_wr) begin
			{qsel_q, idena_q, gena_q} <= {dat_i[6:4], dat_i[1:0]};
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held two cycles");
	a_ack_timing: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	a_marker_flag: assert property (smp_marker_o == smp_valid_o)
		else $error("marker differs from copy valid");
	a_smp_cause: assert property (smp_valid_o |-> $past(frm_valid_i) && $past(gena_q))
		else $error("copy without frame or enable");
	a_smp_queue: assert property (smp_valid_o |-> smp_queue_o == qsel_q)
		else $error("copy on wrong queue");
	a_stamp_id: assert property (smp_valid_o && idena_q |-> smp_stamp_o[31:26] == {2'h0, smp_port_o})
		else $error("stamp sampler number wrong");
	a_mir_cause: assert property (mir_valid_o |-> $past(frm_valid_i))
		else $error("mirror without frame");
	a_mir_probe: assert property (mir_valid_o |-> mir_probe_o != 2'h3)
		else $error("mirror probe out of range");
	a_evt_src: assert property (stat_evt_o[1] |-> smp_valid_o && !smp_tx_o)
		else $error("source event without receive copy");
	a_evt_dst: assert property (stat_evt_o[2] |-> smp_valid_o && smp_tx_o)
		else $error("dest event without transmit copy");
endmodule

`default_nettype wire

// ==== tsm_fwd_model.sv ====
// Forwarding pipeline model issuing one frame decision per request
`timescale 1ns/1ps
`default_nettype none

module tsm_fwd_model (
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// Request from bench
	input wire logic	send_i,
	input wire logic [37:0]	desc_i,
	// Frame toward block
	output var logic	frm_valid_o,
	output var logic [37:0]	frm_o
);
	// Fields toggle between frames so stale values never pass as valid
	always @(posedge clk_i) begin
		frm_valid_o <= send_i && !rst_i;
		if (rst_i) begin
			frm_o <= 38'h0;
		end else if (send_i) begin
			frm_o <= desc_i;
		end else begin
			frm_o <= ~frm_o;
		end
	end
endmodule

`default_nettype wire

// ==== tsm_pkg.sv ====
// Constants and register map for the traffic sampling and mirror probe block
package tsm_pkg;

	// Port layout: front ports, then CPU ports, then virtual device ports
	localparam int NPORT       = 15;
	localparam int NFRONT      = 11;
	localparam int NCPU        = 2;
	localparam int NCPUVD      = 4;
	localparam int PW          = 4;
	localparam int NPROBE      = 3;
	localparam int PRW         = 2;
	localparam int QW          = 3;
	localparam int VIDW        = 12;
	localparam int RATEW       = 16;
	localparam int RNDW        = 15;
	localparam int CNTW        = 32;
	localparam int FIRST_CPU   = 11;

	// Register byte offsets
	localparam logic [11:0] REG_COMMON     = 12'h000;
	localparam logic [11:0] REG_STICKY     = 12'h004;
	localparam logic [11:0] REG_STICKY_MSK = 12'h008;
	localparam logic [11:0] REG_SMP_CTRL   = 12'h040;
	localparam logic [11:0] REG_SMP_COPIES = 12'h080;
	localparam logic [11:0] REG_SMP_CAND   = 12'h0C0;
	localparam logic [11:0] REG_PROBE_BASE = 12'h100;
	localparam logic [11:0] REG_PROBE_CFG  = 12'h000;
	localparam logic [11:0] REG_PROBE_PORT = 12'h004;

	// Common register fields
	localparam int COM_ENA   = 0;
	localparam int COM_IDENA = 1;
	localparam int COM_QU_LO = 4;
	localparam int COM_FLOOD = 8;

	// Sampler control fields
	localparam int SC_RATE_LO = 0;
	localparam int SC_DIR_LO  = 16;
	localparam int DIR_RX     = 0;
	localparam int DIR_TX     = 1;

	// Probe config fields
	localparam int PC_DIR_LO  = 0;
	localparam int PC_MAC_LO  = 2;
	localparam int PC_VLAN_LO = 4;
	localparam int PC_VID_LO  = 6;
	localparam int PC_CPU_LO  = 18;
	localparam int PC_RXC_LO  = 20;
	localparam int PC_DST_LO  = 24;
	localparam int PDIR_TX    = 0;
	localparam int PDIR_RX    = 1;
	localparam int MAC_TO     = 0;
	localparam int MAC_FROM   = 1;
	localparam logic [1:0] VLAN_BY_FLAG = 2'h1;
	localparam logic [1:0] VLAN_BY_VID  = 2'h2;

	// Sticky event bits
	localparam int EV_CAND = 0;
	localparam int EV_SRC  = 1;
	localparam int EV_DST  = 2;
	localparam int NEV     = 3;

	// Stamp layout with sampler number
	localparam int ST_ID_LO  = 26;
	localparam int ST_FWD_LO = 8;
	localparam int ST_CNT_LO = 0;

	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

endpackage

// ==== tsm_top.sv ====
// Statistical frame sampler, mirror probes and their register file
// Operation
// RULE1: rate field sets probability in 1/32768 steps
// RULE2: each candidate has equal independent chance; all port LFSRs share one seed, so same-cycle draws match
// RULE3: direction bit 0 samples received frames
// RULE4: direction bit 1 samples transmitted frames
// RULE5: receive and transmit enables act independently
// RULE6: copies go to global extraction queue
// RULE7: copy carries marker flag and stamp
// RULE8: stamp holds sampler number, forward, sample counts
// RULE9: software enables stamp id for transmit sampling
// RULE10: copies sent counter per port, readable
// RULE11: candidate forward counter per port, readable
// RULE12: sticky flags for candidate, source, destination copy
// RULE13: masked sticky events counted in statistics
// RULE14: three probes, own filters and destination
// RULE15: probe matches only when all enabled filters hold
// RULE16: highest matching probe wins, one copy
// RULE17: receive bit mirrors frames from masked ports
// RULE18: transmit bit mirrors frames to masked ports
// RULE19: VLAN mode 2 by VID, 1 by flag
// RULE20: station filter from and to flagged stations
// RULE21: classifier-chosen probe uses direction only
// RULE22: receive mask covers CPU and virtual ports
// RULE23: pseudo-random 15-bit value below rate chooses
`timescale 1ns/1ps
`default_nettype none

module tsm_top (
	// Clock and reset
	input  wire logic                               clk_i,
	input  wire logic                               rst_i,
	// Wishbone slave
	input  wire logic                               cyc_i,
	input  wire logic                               stb_i,
	input  wire logic                               we_i,
	input  wire logic [11:0]                        adr_i,
	input  wire logic [3:0]                         sel_i,
	input  wire logic [31:0]                        dat_i,
	output logic      [31:0]                        dat_o,
	output logic                                    ack_o,
	// Frame from forwarding pipeline
	input  wire logic                               frm_valid_i,
	input  wire logic [tsm_pkg::PW-1:0]             frm_src_port_i,
	input  wire logic [tsm_pkg::NPORT-1:0]          frm_dst_mask_i,
	input  wire logic [tsm_pkg::VIDW-1:0]           frm_vid_i,
	input  wire logic                               frm_vlan_mirror_i,
	input  wire logic                               frm_smac_mirror_i,
	input  wire logic                               frm_dmac_mirror_i,
	input  wire logic                               frm_flooded_i,
	input  wire logic                               frm_cls_probe_valid_i,
	input  wire logic [tsm_pkg::PRW-1:0]            frm_cls_probe_i,
	// Sampled copy to CPU extraction
	output logic                                    smp_valid_o,
	output logic [tsm_pkg::PW-1:0]                  smp_port_o,
	output logic                                    smp_tx_o,
	output logic [tsm_pkg::QW-1:0]                  smp_queue_o,
	output logic                                    smp_marker_o,
	output logic [31:0]                             smp_stamp_o,
	// Mirror copy request
	output logic                                    mir_valid_o,
	output logic [tsm_pkg::PRW-1:0]                 mir_probe_o,
	output logic [tsm_pkg::PW-1:0]                  mir_dst_port_o,
	// Event counting toward the port statistics block
	output logic [tsm_pkg::NEV-1:0]                 stat_evt_o,
	output logic [tsm_pkg::PW-1:0]                  stat_port_o
);

	// Register storage
	logic [31:0]                     common_q;
	logic [tsm_pkg::NEV-1:0]         sticky_q;
	logic [tsm_pkg::NEV-1:0]         sticky_d;
	logic [tsm_pkg::NEV-1:0]         smask_q;
	logic [31:0]                     sctrl_q  [tsm_pkg::NPORT];
	logic [tsm_pkg::CNTW-1:0]        copies_q [tsm_pkg::NPORT];
	logic [tsm_pkg::CNTW-1:0]        cand_q   [tsm_pkg::NPORT];
	logic [31:0]                     pcfg_q   [tsm_pkg::NPROBE];
	logic [tsm_pkg::NPORT-1:0]       pport_q  [tsm_pkg::NPROBE];

	// Bus decode
	wire        req      = cyc_i & stb_i & ~ack_o;
	wire        wr       = req & we_i;
	wire [31:0] wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [9:0]  widx     = adr_i[11:2];
	// Per-port words sit four bytes apart inside each 64-byte window
	wire [5:0]  p_idx    = {2'h0, adr_i[5:2]};
	wire [3:0]  pr_idx   = adr_i[7:4];
	wire        in_ctrl  = (adr_i[11:6] == tsm_pkg::REG_SMP_CTRL[11:6]);
	wire        in_copy  = (adr_i[11:6] == tsm_pkg::REG_SMP_COPIES[11:6]);
	wire        in_cand  = (adr_i[11:6] == tsm_pkg::REG_SMP_CAND[11:6]);
	wire        in_probe = (adr_i[11:8] == tsm_pkg::REG_PROBE_BASE[11:8]);
	wire        port_ok  = (p_idx < 6'(tsm_pkg::NPORT));
	wire        probe_ok = (pr_idx < 4'(tsm_pkg::NPROBE));
	wire        pr_cfg   = (adr_i[3:0] == tsm_pkg::REG_PROBE_CFG[3:0]);
	wire        pr_port  = (adr_i[3:0] == tsm_pkg::REG_PROBE_PORT[3:0]);

	// Global settings
	wire                      glob_ena  = common_q[tsm_pkg::COM_ENA];
	wire                      id_ena    = common_q[tsm_pkg::COM_IDENA];
	wire [tsm_pkg::QW-1:0]    queue_sel = common_q[tsm_pkg::COM_QU_LO +: tsm_pkg::QW];
	wire                      flood_ena = common_q[tsm_pkg::COM_FLOOD];

	// Per-port sampler decisions
	logic [tsm_pkg::NPORT-1:0] rx_cand;
	logic [tsm_pkg::NPORT-1:0] tx_cand;
	logic [tsm_pkg::NPORT-1:0] any_cand;
	logic [tsm_pkg::NPORT-1:0] chosen;
	logic [tsm_pkg::NPORT-1:0] sent;
	logic [tsm_pkg::CNTW-1:0]  cand_nx  [tsm_pkg::NPORT];
	logic [tsm_pkg::CNTW-1:0]  copy_nx  [tsm_pkg::NPORT];

	genvar gp;
	generate
		for (gp = 0; gp < tsm_pkg::NPORT; gp++) begin : g_smp
			logic [15:0] lfsr_q;
			wire  [tsm_pkg::RATEW-1:0] rate = sctrl_q[gp][tsm_pkg::SC_RATE_LO +: tsm_pkg::RATEW];
			wire  [1:0] dsel = sctrl_q[gp][tsm_pkg::SC_DIR_LO +: 2];
			wire  [tsm_pkg::RATEW-1:0] draw = {1'b0, lfsr_q[tsm_pkg::RNDW-1:0]};
			// Free running, so a draw never depends on earlier outcomes
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					lfsr_q <= tsm_pkg::LFSR_SEED;
				end else begin
					lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ tsm_pkg::LFSR_TAPS) : (lfsr_q >> 1); // [RULE2]
				end
			end
			assign rx_cand[gp]  = glob_ena & frm_valid_i & dsel[tsm_pkg::DIR_RX]
				& (frm_src_port_i == 4'(gp)); // [RULE3] [RULE5]
			assign tx_cand[gp]  = glob_ena & frm_valid_i & dsel[tsm_pkg::DIR_TX]
				& frm_dst_mask_i[gp]; // [RULE4] [RULE5]
			assign any_cand[gp] = rx_cand[gp] | tx_cand[gp];
			assign chosen[gp]   = any_cand[gp] & (draw < rate); // [RULE1] [RULE23]
			assign cand_nx[gp]  = cand_q[gp] + tsm_pkg::CNTW'(any_cand[gp]); // [RULE11]
			assign copy_nx[gp]  = copies_q[gp] + tsm_pkg::CNTW'(sent[gp]); // [RULE10]
		end
	endgenerate

	// One copy per frame: the receiving sampler first, else lowest transmit port
	function automatic logic [tsm_pkg::PW:0] lowest(input logic [tsm_pkg::NPORT-1:0] v);
		logic [tsm_pkg::PW:0] r;
		r = '0;
		for (int i = tsm_pkg::NPORT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	wire                  rx_win   = |(chosen & rx_cand);
	wire [tsm_pkg::PW:0]  tx_pick  = lowest(chosen & ~rx_cand);
	wire                  smp_any  = rx_win | tx_pick[tsm_pkg::PW];
	wire [tsm_pkg::PW-1:0] smp_p   = rx_win ? frm_src_port_i : tx_pick[tsm_pkg::PW-1:0];
	assign sent = smp_any ? (tsm_pkg::NPORT'(1) << smp_p) : '0;

	wire [tsm_pkg::CNTW-1:0] fwd_v = cand_nx[smp_p];
	wire [tsm_pkg::CNTW-1:0] cnt_v = copy_nx[smp_p];
	// Field widths follow from the stamp bit positions
	localparam int IDP_W = 32 - tsm_pkg::ST_ID_LO - tsm_pkg::PW;
	localparam int FID_W = tsm_pkg::ST_ID_LO - tsm_pkg::ST_FWD_LO;
	localparam int FNO_W = 32 - tsm_pkg::ST_FWD_LO;
	localparam int SCN_W = tsm_pkg::ST_FWD_LO - tsm_pkg::ST_CNT_LO;
	wire [31:0] stamp_id = {IDP_W'(0), smp_p, fwd_v[FID_W-1:0], cnt_v[SCN_W-1:0]}; // [RULE8]
	wire [31:0] stamp_no = {fwd_v[FNO_W-1:0], cnt_v[SCN_W-1:0]};
	wire [31:0] stamp    = id_ena ? stamp_id : stamp_no;

	// Sticky events
	logic [tsm_pkg::NEV-1:0] ev;
	assign ev[tsm_pkg::EV_CAND] = |any_cand;
	assign ev[tsm_pkg::EV_SRC]  = smp_any & rx_win;
	assign ev[tsm_pkg::EV_DST]  = smp_any & ~rx_win;
	wire [tsm_pkg::NEV-1:0] st_clr = (wr && widx == tsm_pkg::REG_STICKY[11:2] && sel_i[0])
		? dat_i[tsm_pkg::NEV-1:0] : '0;
	assign sticky_d = (sticky_q & ~st_clr) | ev; // [RULE12]

	// Mirror probe matching
	logic [tsm_pkg::NPROBE-1:0] pmatch;
	wire  [tsm_pkg::PW-1:0]     cpu_off = frm_src_port_i - 4'(tsm_pkg::FIRST_CPU);
	wire                        src_cpu = (frm_src_port_i >= 4'(tsm_pkg::FIRST_CPU));

	generate
		for (gp = 0; gp < tsm_pkg::NPROBE; gp++) begin : g_probe
			wire [1:0] pdir  = pcfg_q[gp][tsm_pkg::PC_DIR_LO +: 2];
			wire [1:0] pmac  = pcfg_q[gp][tsm_pkg::PC_MAC_LO +: 2];
			wire [1:0] pvlan = pcfg_q[gp][tsm_pkg::PC_VLAN_LO +: 2];
			wire [tsm_pkg::VIDW-1:0] pvid = pcfg_q[gp][tsm_pkg::PC_VID_LO +: tsm_pkg::VIDW];
			wire [tsm_pkg::NCPU-1:0] pcpu = pcfg_q[gp][tsm_pkg::PC_CPU_LO +: tsm_pkg::NCPU];
			wire [tsm_pkg::NCPUVD-1:0] prxc = pcfg_q[gp][tsm_pkg::PC_RXC_LO +: tsm_pkg::NCPUVD];
			wire front_rx = ~src_cpu & pport_q[gp][frm_src_port_i];
			wire cpu_rx   = src_cpu & prxc[cpu_off[1:0]]; // [RULE22]
			wire rx_hit   = pdir[tsm_pkg::PDIR_RX] & (front_rx | cpu_rx); // [RULE17]
			wire tx_front = |(frm_dst_mask_i[tsm_pkg::NFRONT-1:0]
				& pport_q[gp][tsm_pkg::NFRONT-1:0]);
			wire tx_cpu   = |(frm_dst_mask_i[tsm_pkg::FIRST_CPU +: tsm_pkg::NCPU] & pcpu);
			wire tx_hit   = pdir[tsm_pkg::PDIR_TX] & (tx_front | tx_cpu); // [RULE18]
			wire vlan_ok  = (pvlan == tsm_pkg::VLAN_BY_VID)  ? (frm_vid_i == pvid) :
			                (pvlan == tsm_pkg::VLAN_BY_FLAG) ? frm_vlan_mirror_i : 1'b1; // [RULE19]
			wire from_ok  = ~pmac[tsm_pkg::MAC_FROM] | frm_smac_mirror_i;
			wire to_ok    = ~pmac[tsm_pkg::MAC_TO] | frm_dmac_mirror_i
				| (frm_flooded_i & flood_ena); // [RULE20]
			wire by_cls   = frm_cls_probe_valid_i & (frm_cls_probe_i == 2'(gp));
			// Classifier selection bypasses every filter but direction
			assign pmatch[gp] = frm_valid_i & (by_cls ? (|pdir) // [RULE21]
				: ((rx_hit | tx_hit) & vlan_ok & from_ok & to_ok)); // [RULE15] [RULE14]
		end
	endgenerate

	// Highest numbered matching probe
	function automatic logic [tsm_pkg::PRW:0] highest(input logic [tsm_pkg::NPROBE-1:0] v);
		logic [tsm_pkg::PRW:0] r;
		r = '0;
		for (int i = 0; i < tsm_pkg::NPROBE; i++) begin
			if (v[i]) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	wire [tsm_pkg::PRW:0] pwin = highest(pmatch); // [RULE16]
	wire [tsm_pkg::PW-1:0] pdst = pcfg_q[pwin[tsm_pkg::PRW-1:0]][tsm_pkg::PC_DST_LO +: tsm_pkg::PW];

	// Read mux
	logic [31:0] rdata;
	always_comb begin
		rdata = '0;
		if (widx == tsm_pkg::REG_COMMON[11:2]) begin
			rdata = common_q;
		end else if (widx == tsm_pkg::REG_STICKY[11:2]) begin
			rdata = 32'(sticky_q);
		end else if (widx == tsm_pkg::REG_STICKY_MSK[11:2]) begin
			rdata = 32'(smask_q);
		end else if (in_ctrl && port_ok) begin
			rdata = sctrl_q[p_idx[3:0]];
		end else if (in_copy && port_ok) begin
			rdata = copies_q[p_idx[3:0]]; // [RULE10]
		end else if (in_cand && port_ok) begin
			rdata = cand_q[p_idx[3:0]]; // [RULE11]
		end else if (in_probe && probe_ok && pr_cfg) begin
			rdata = pcfg_q[pr_idx[1:0]];
		end else if (in_probe && probe_ok && pr_port) begin
			rdata = 32'(pport_q[pr_idx[1:0]]);
		end
	end

	// Bus answer: ack one cycle after the request, for every address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req;
			dat_o <= (req & ~we_i) ? rdata : '0;
		end
	end

	// Global and sticky registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			common_q <= '0;
			sticky_q <= '0;
			smask_q  <= '0;
		end else begin
			sticky_q <= sticky_d;
			if (wr && widx == tsm_pkg::REG_COMMON[11:2]) begin
				common_q <= (common_q & ~wmask) | (dat_i & wmask);
			end
			if (wr && widx == tsm_pkg::REG_STICKY_MSK[11:2] && sel_i[0]) begin
				smask_q <= dat_i[tsm_pkg::NEV-1:0];
			end
		end
	end

	// Per-port sampler registers; a counter event wins over a write
	generate
		for (gp = 0; gp < tsm_pkg::NPORT; gp++) begin : g_sreg
			wire hit = port_ok & (p_idx[3:0] == 4'(gp));
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sctrl_q[gp] <= '0;
				end else if (wr && in_ctrl && hit) begin
					sctrl_q[gp] <= (sctrl_q[gp] & ~wmask) | (dat_i & wmask);
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					copies_q[gp] <= '0;
				end else if (sent[gp] || !(wr && in_copy && hit)) begin
					copies_q[gp] <= copy_nx[gp];
				end else begin
					copies_q[gp] <= (copies_q[gp] & ~wmask) | (dat_i & wmask);
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cand_q[gp] <= '0;
				end else if (any_cand[gp] || !(wr && in_cand && hit)) begin
					cand_q[gp] <= cand_nx[gp];
				end else begin
					cand_q[gp] <= (cand_q[gp] & ~wmask) | (dat_i & wmask);
				end
			end
		end
	endgenerate

	// Probe registers
	generate
		for (gp = 0; gp < tsm_pkg::NPROBE; gp++) begin : g_preg
			wire hit = in_probe & (pr_idx == 4'(gp));
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pcfg_q[gp]  <= '0;
					pport_q[gp] <= '0;
				end else begin
					if (wr && hit && pr_cfg) begin
						pcfg_q[gp] <= (pcfg_q[gp] & ~wmask) | (dat_i & wmask);
					end
					if (wr && hit && pr_port) begin
						pport_q[gp] <= (pport_q[gp] & ~wmask[tsm_pkg::NPORT-1:0])
							| (dat_i[tsm_pkg::NPORT-1:0] & wmask[tsm_pkg::NPORT-1:0]);
					end
				end
			end
		end
	endgenerate

	// Registered sampled copy toward CPU extraction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smp_valid_o  <= 1'b0;
			smp_port_o   <= '0;
			smp_tx_o     <= 1'b0;
			smp_queue_o  <= '0;
			smp_marker_o <= 1'b0;
			smp_stamp_o  <= '0;
		end else begin
			smp_valid_o  <= smp_any;
			smp_port_o   <= smp_p;
			smp_tx_o     <= ~rx_win;
			smp_queue_o  <= queue_sel; // [RULE6]
			smp_marker_o <= smp_any; // [RULE7]
			smp_stamp_o  <= stamp; // [RULE7]
		end
	end

	// Registered mirror copy request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mir_valid_o    <= 1'b0;
			mir_probe_o    <= '0;
			mir_dst_port_o <= '0;
		end else begin
			mir_valid_o    <= pwin[tsm_pkg::PRW];
			mir_probe_o    <= pwin[tsm_pkg::PRW-1:0];
			mir_dst_port_o <= pdst; // [RULE14]
		end
	end

	// Registered event pulses toward port statistics
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_evt_o  <= '0;
			stat_port_o <= '0;
		end else begin
			stat_evt_o  <= ev & smask_q; // [RULE13]
			stat_port_o <= smp_any ? smp_p : frm_src_port_i;
		end
	end

endmodule

`default_nettype wire
